// >>> inc/machine_step_defs.svh
// constants for the machine step sequencer: timing counts, step count and io layout
// assumes a 100 MHz system clock shared with the input debouncer
//
// Behaviour
// - start only after the programmed start-condition combination is seen on debounced inputs
// - once started, walk actuator outputs through a fixed step order with timed waits
// - advance steps 0 to 2 only when their limit switch confirms completion; the last step awaits none
// - a step exceeding its allowed time is a jam and aborts the sequence
// - six machine inputs and five outputs; three and two of them logic level
// - outputs, delay timer and step advance are decided from inputs plus internal state
// - every machine input is debounced before the decision logic samples it
// - a startup delay signal holds behaviour off after power-up until it changes
// - all sequential elements run from the one debouncer system clock
// - step counter only increments by one or resets to zero, else holds
// - step number is shown as seven-segment code and fed back as bcd
// - step delays combine timer taps, giving lengths from 50 ms to 12 s
// - logic-level outputs come straight from decision logic, usable as pulses
`ifndef MACHINE_STEP_DEFS_SVH
`define MACHINE_STEP_DEFS_SVH

`define CLK_MHZ          100
`define DEB_TICK_US      1000
`define DEB_TICK_CYC     (`DEB_TICK_US * `CLK_MHZ)
`define DEB_SAMPLES      4
`define STARTUP_TICKS    50
`define DELAY_UNIT_MS    50
`define DELAY_UNIT_TICKS (`DELAY_UNIT_MS * 1000 / `DEB_TICK_US)
`define DELAY_MIN_MS     50
`define DELAY_MAX_MS     12000
`define DELAY_MAX_UNITS  (`DELAY_MAX_MS / `DELAY_UNIT_MS)
`define JAM_UNITS        60
`define NUM_STEPS        4
`define N_INPUTS         6
`define N_OUTPUTS        5
// input bit positions
`define IN_START         0
`define IN_GUARD         1
`define IN_PART          2
`define IN_LIMIT_A       3
`define IN_LIMIT_B       4
`define IN_LIMIT_C       5
// output bit positions
`define OUT_SOL_A        0
`define OUT_SOL_B        1
`define OUT_SOL_C        2
`define OUT_CLR_PULSE    3
`define OUT_CONV_PULSE   4

`endif

// >>> inc/machine_step_pkg.sv
// types for the machine step sequencer
// assumes machine_step_defs.svh supplies the numeric constants
package machine_step_pkg;

	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_HOLD  = 5'h01,
		ST_IDLE  = 5'h02,
		ST_DRIVE = 5'h04,
		ST_WAIT  = 5'h08,
		ST_DONE  = 5'h10
	} seq_state_t;

	// step counter actions
	typedef enum logic [1:0] {
		CNT_HOLD = 2'h0,
		CNT_INC  = 2'h1,
		CNT_CLR  = 2'h2
	} cnt_op_t;

endpackage : machine_step_pkg

// >>> design/machine_step_sequencer.sv
// step sequencer: debounced inputs, step counter, timed waits, jam abort
// assumes raw machine inputs are asynchronous and the clock is 100 MHz
`timescale 1ns/100ps
`include "machine_step_defs.svh"

module machine_step_sequencer
	import machine_step_pkg::*;
#(
	parameter int DEB_TICK_CYC = `DEB_TICK_CYC,
	parameter int STARTUP_TICKS = `STARTUP_TICKS,
	parameter int DELAY_UNIT_TICKS = `DELAY_UNIT_TICKS
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// raw machine inputs
	input  wire logic [5:0] mach_in,
	// startup delay line from the delayed debouncer section
	input  wire logic       startup_in,
	// machine outputs: three solenoids, two logic-level pulses
	output logic      [4:0] mach_out,
	// step display
	output logic      [6:0] seg_out,
	output logic      [3:0] step_bcd,
	// status
	output logic            jam_flag,
	output logic            busy
);

	// refuse timings the counters cannot hold: the unit prescaler is only 16 bits wide
	if (DEB_TICK_CYC < 2 || STARTUP_TICKS < 1 || DELAY_UNIT_TICKS < 1
		|| DELAY_UNIT_TICKS > 65536) begin : g_bad_timing
		$error("machine_step_sequencer: bad timing parameter");
	end

	//////////////////////////////////////////////////////////////////////
	// debounce clock: one enable pulse per tick, also the base of the 50 ms unit
	logic [31:0] tick_cnt_ff;
	logic        tick_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_cnt_ff <= 32'h0;
			tick_ff     <= 1'b0;
		end else if (tick_cnt_ff == 32'(DEB_TICK_CYC - 1)) begin
			tick_cnt_ff <= 32'h0;
			tick_ff     <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h1;
			tick_ff     <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// synchronise then debounce each input, startup line as bit 6
	logic [6:0] raw_all;
	logic [6:0] sync1_ff;
	logic [6:0] sync2_ff;
	logic [6:0] deb_ff;

	assign raw_all = {startup_in, mach_in};

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 7'h00;
			sync2_ff <= 7'h00;
		end else begin
			sync1_ff <= raw_all;
			sync2_ff <= sync1_ff;
		end
	end

	// an input must sit steady for several ticks; short contact bounce is ignored
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++) begin : g_deb
			logic [2:0] same_ff;
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					same_ff      <= 3'h0;
					deb_ff[gi]   <= 1'b0;
				end else if (tick_ff) begin
					if (sync2_ff[gi] == deb_ff[gi]) begin
						same_ff <= 3'h0;
					end else if (same_ff == 3'(`DEB_SAMPLES - 1)) begin
						same_ff    <= 3'h0;
						deb_ff[gi] <= sync2_ff[gi];
					end else begin
						same_ff <= same_ff + 3'h1;
					end
				end
			end
		end
	endgenerate

	// start needs all three start inputs at once; limits are the three switch bits
	logic       start_ok;
	logic [2:0] limits;
	assign start_ok = deb_ff[`IN_START] & deb_ff[`IN_GUARD] & deb_ff[`IN_PART];
	assign limits   = deb_ff[`IN_LIMIT_C:`IN_LIMIT_A];

	//////////////////////////////////////////////////////////////////////
	// programmable timer: tick counter yields a 50 ms unit, unit counter taps
	logic [15:0] unit_pre_ff;
	logic        unit_ff;
	logic [7:0]  unit_cnt_ff;
	logic        unit_clr;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			unit_pre_ff <= 16'h0000;
			unit_ff     <= 1'b0;
		end else if (unit_clr) begin
			unit_pre_ff <= 16'h0000;
			unit_ff     <= 1'b0;
		end else if (tick_ff && unit_pre_ff == 16'(DELAY_UNIT_TICKS - 1)) begin
			unit_pre_ff <= 16'h0000;
			unit_ff     <= 1'b1;
		end else begin
			unit_pre_ff <= tick_ff ? unit_pre_ff + 16'h0001 : unit_pre_ff;
			unit_ff     <= 1'b0;
		end
	end

	// unit counter saturates so a stalled step keeps reading as over time
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			unit_cnt_ff <= 8'h00;
		else if (unit_clr)
			unit_cnt_ff <= 8'h00;
		else if (unit_ff && unit_cnt_ff != 8'hFF)
			unit_cnt_ff <= unit_cnt_ff + 8'h01;
	end

	//////////////////////////////////////////////////////////////////////
	// fixed program: per step solenoid pattern, awaited limit, wait length
	function automatic logic [2:0] step_sol(input logic [3:0] s);
		case (s)
			4'h0:    step_sol = 3'h1;
			4'h1:    step_sol = 3'h3;
			4'h2:    step_sol = 3'h6;
			default: step_sol = 3'h4;
		endcase
	endfunction : step_sol

	function automatic logic [2:0] step_lim(input logic [3:0] s);
		case (s)
			4'h0:    step_lim = 3'h1;
			4'h1:    step_lim = 3'h2;
			4'h2:    step_lim = 3'h4;
			default: step_lim = 3'h0;
		endcase
	endfunction : step_lim

	// wait in 50 ms units; taps combined give 50 ms up to 12 s
	function automatic logic [7:0] step_wait(input logic [3:0] s);
		case (s)
			4'h0:    step_wait = 8'h01;
			4'h1:    step_wait = 8'h0A;
			4'h2:    step_wait = 8'(`DELAY_MAX_UNITS);
			default: step_wait = 8'h00;
		endcase
	endfunction : step_wait

	//////////////////////////////////////////////////////////////////////
	// decision logic: next state, counter action, timer clear, pulses
	seq_state_t  state_ff;
	seq_state_t  nxt_state;
	cnt_op_t     cnt_op;
	logic [3:0]  step_ff;
	logic        startup_seen_ff;
	logic        pulse_clr;
	logic        pulse_conv;
	logic        abort;

	always_comb begin
		nxt_state  = state_ff;
		cnt_op     = CNT_HOLD;
		unit_clr   = 1'b0;
		pulse_clr  = 1'b0;
		pulse_conv = 1'b0;
		abort      = 1'b0;
		case (state_ff)
			ST_HOLD: begin
				if (startup_seen_ff)
					nxt_state = ST_IDLE;
			end
			ST_IDLE: begin
				if (start_ok) begin
					nxt_state = ST_DRIVE;
					cnt_op    = CNT_CLR;
					unit_clr  = 1'b1;
					pulse_clr = 1'b1;
				end
			end
			ST_DRIVE: begin
				if ((limits & step_lim(step_ff)) == step_lim(step_ff)) begin
					nxt_state = ST_WAIT;
					unit_clr  = 1'b1;
				end else if (unit_cnt_ff >= 8'(`JAM_UNITS)) begin
					nxt_state = ST_DONE;
					abort     = 1'b1;
				end
			end
			ST_WAIT: begin
				if (unit_cnt_ff >= step_wait(step_ff)) begin
					unit_clr = 1'b1;
					if (step_ff == 4'(`NUM_STEPS - 1)) begin
						nxt_state  = ST_DONE;
						pulse_conv = 1'b1;
					end else begin
						nxt_state = ST_DRIVE;
						cnt_op    = CNT_INC;
					end
				end
			end
			ST_DONE: begin
				cnt_op    = CNT_CLR;
				nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_HOLD;
		endcase
	end

	// state register; reset parks the sequencer until the startup line is seen
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			state_ff <= ST_HOLD;
		else
			state_ff <= nxt_state;
	end

	// startup line must rise once before anything moves
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			startup_seen_ff <= 1'b0;
		else if (deb_ff[6])
			startup_seen_ff <= 1'b1;
	end

	// step counter: increment, clear, or hold, nothing else
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			step_ff <= 4'h0;
		else if (cnt_op == CNT_CLR)
			step_ff <= 4'h0;
		else if (cnt_op == CNT_INC)
			step_ff <= (step_ff == 4'h9) ? 4'h0 : step_ff + 4'h1;
	end

	//////////////////////////////////////////////////////////////////////
	// registered outputs; solenoids only while driving or waiting
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mach_out <= 5'h00;
		end else begin
			mach_out[`OUT_SOL_C:`OUT_SOL_A] <= (nxt_state == ST_DRIVE || nxt_state == ST_WAIT)
				? step_sol(cnt_op == CNT_INC ? step_ff + 4'h1 :
					(cnt_op == CNT_CLR ? 4'h0 : step_ff)) : 3'h0;
			mach_out[`OUT_CLR_PULSE]  <= pulse_clr;
			mach_out[`OUT_CONV_PULSE] <= pulse_conv;
		end
	end

	// display decode from the counter; bcd is fed back via step_ff
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seg_out  <= 7'h3F;
			step_bcd <= 4'h0;
		end else begin
			step_bcd <= step_ff;
			case (step_ff)
				4'h0:    seg_out <= 7'h3F;
				4'h1:    seg_out <= 7'h06;
				4'h2:    seg_out <= 7'h5B;
				4'h3:    seg_out <= 7'h4F;
				4'h4:    seg_out <= 7'h66;
				4'h5:    seg_out <= 7'h6D;
				4'h6:    seg_out <= 7'h7D;
				4'h7:    seg_out <= 7'h07;
				4'h8:    seg_out <= 7'h7F;
				default: seg_out <= 7'h6F;
			endcase
		end
	end

	// jam flag holds until the next start; busy tracks a running sequence
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			jam_flag <= 1'b0;
			busy     <= 1'b0;
		end else begin
			if (abort)
				jam_flag <= 1'b1;
			else if (state_ff == ST_IDLE && start_ok)
				jam_flag <= 1'b0;
			busy <= (nxt_state == ST_DRIVE || nxt_state == ST_WAIT);
		end
	end

endmodule : machine_step_sequencer

// >>> verif/machine_model.sv
// machine model: limit switches close after solenoid travel
// assumes the bench drives the start inputs
`timescale 1ns/100ps
module machine_model #(
	parameter int TRAVEL = 40
) (
	// clock and solenoids
	input  wire logic       sys_clk,
	input  wire logic [4:0] mach_out,
	// jam request from the bench
	input  wire logic       jam,
	// limit switches A..C
	output logic      [2:0] limit_sw
);
	int cnt [3];
	initial limit_sw = 3'h0;
	// a jammed part never reaches its limit
	always @(negedge sys_clk) begin
		for (int i = 0; i < 3; i++) begin
			cnt[i] = mach_out[i] ? cnt[i] + 1 : 0;
			limit_sw[i] <= !jam && cnt[i] > TRAVEL;
		end
	end
endmodule : machine_model

// >>> verif/machine_step_assertions.sv
// port checker for the step sequencer
// assumes it is bound to the sequencer top
`timescale 1ns/100ps
module machine_step_checker (
	// clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// machine side
	input wire logic [5:0] mach_in,
	input wire logic       startup_in,
	input wire logic [4:0] mach_out,
	// display and status
	input wire logic [6:0] seg_out,
	input wire logic [3:0] step_bcd,
	input wire logic       jam_flag,
	input wire logic       busy
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// segment codes {g..a} of the steps used
	logic [6:0] seg_tab [4] = '{7'h3F, 7'h06, 7'h5B, 7'h4F};
	// raw startup line seen high once; the permit it gives is sticky
	logic       startup_hi_ff;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			startup_hi_ff <= 1'b0;
		else if (startup_in)
			startup_hi_ff <= 1'b1;
	end
	////////////////////////////////////////
	clr_pulse_a: assert property (mach_out[3] |=> !mach_out[3])
		else $error("clear pulse too long");
	conv_pulse_a: assert property (mach_out[4] |=> !mach_out[4])
		else $error("convert pulse too long");
	start_out_a: assert property ($rose(busy) |-> mach_out[3] && mach_out[2:0] == 3'h1)
		else $error("bad first step outputs");
	start_cond_a: assert property ($rose(busy) |-> $past(mach_in[2:0], 4) == 3'h7
		&& startup_hi_ff) else $error("start without conditions");
	end_off_a: assert property ($fell(busy) |-> ##[0:2]
		(mach_out[2:0] == 3'h0 && step_bcd == 4'h0)) else $error("outputs left on");
	jam_abort_a: assert property ($rose(jam_flag) |-> ##[0:1]
		(!busy && mach_out[2:0] == 3'h0)) else $error("jam did not abort");
	step_move_a: assert property ($changed(step_bcd) |-> step_bcd == 4'h0
		|| step_bcd == $past(step_bcd) + 4'h1) else $error("step jumped");
	seg_code_a: assert property (step_bcd < 4'h4 |-> seg_out == seg_tab[step_bcd[1:0]])
		else $error("segment code wrong");
	// main scenarios reached
	cover property ($rose(busy));
	cover property ($rose(jam_flag));
	cover property (mach_out[4]);
	cover property (step_bcd == 4'h3);
endmodule : machine_step_checker

bind machine_step_sequencer machine_step_checker chk (.sys_clk(sys_clk), .rst(rst),
	.mach_in(mach_in), .startup_in(startup_in), .mach_out(mach_out), .seg_out(seg_out),
	.step_bcd(step_bcd), .jam_flag(jam_flag), .busy(busy));

// >>> verif/machine_step_sequencer_test.sv
// testbench for the step sequencer with a machine model
// assumes shortened tick and unit parameters
`timescale 1ns/100ps
module machine_step_sequencer_test;
	localparam int TICK = 4;
	localparam int UNIT = 2;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic [2:0] ctl = 3'h0;
	logic       startup_in = 1'b0;
	logic       jam = 1'b0;
	logic [2:0] limit_sw;
	logic [4:0] mach_out;
	logic [6:0] seg_out;
	logic [3:0] step_bcd;
	logic       jam_flag;
	logic       busy;
	int         fail_count = 0;
	int         total_checks = 0;
	int         waited;
	////////////////////////////////////////
	// clock, design and machine
	always #5 sys_clk = ~sys_clk;
	machine_step_sequencer #(.DEB_TICK_CYC(TICK), .STARTUP_TICKS(2),
		.DELAY_UNIT_TICKS(UNIT)) uut (.sys_clk(sys_clk), .rst(rst),
		.mach_in({limit_sw, ctl}), .startup_in(startup_in), .mach_out(mach_out),
		.seg_out(seg_out), .step_bcd(step_bcd), .jam_flag(jam_flag), .busy(busy));
	machine_model mdl (.sys_clk(sys_clk), .mach_out(mach_out), .jam(jam),
		.limit_sw(limit_sw));
	////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	// selects: busy, jam flag, convert pulse, else step number s - 3
	function automatic logic cond(input int s);
		case (s)
			0: return busy === 1'b1;
			1: return jam_flag === 1'b1;
			2: return mach_out[4] === 1'b1;
			default: return step_bcd === 4'(s - 3);
		endcase
	endfunction : cond
	// bounded wait, leaves the cycle count in waited
	task automatic wait_on(input int s, input int lim);
		int n;
		for (n = 0; n < lim && !cond(s); n++)
			@(negedge sys_clk);
		waited = n;
		if (n == lim) begin
			fail_count++;
			$display("[ERR] %0t wait ran out", $time);
			stop_test();
		end
	endtask : wait_on
	////////////////////////////////////////
	task automatic t_hold();
		check({mach_out, seg_out, step_bcd, jam_flag, busy}, 16'h0FC0);
		ctl = 3'h7;
		repeat (200) @(negedge sys_clk);
		check(busy, 1'b0);
		ctl = 3'h0;
		repeat (40) @(negedge sys_clk);
		startup_in = 1'b1;
		repeat (40) @(negedge sys_clk);
		$display("hold done");
	endtask : t_hold
	task automatic t_partial();
		logic [2:0] part [3] = '{3'h3, 3'h5, 3'h6};
		for (int i = 0; i < 3; i++) begin
			ctl = part[i];
			repeat (80) @(negedge sys_clk);
			check(busy, 1'b0);
		end
		ctl = 3'h0;
		repeat (40) @(negedge sys_clk);
		$display("partial done");
	endtask : t_partial
	// full run; returns once outputs are idle again
	task automatic t_run();
		ctl = 3'h7;
		wait_on(0, 200);
		ctl = 3'h0;
		check(mach_out, 5'h09);
		wait_on(4, 3000);
		check(mach_out[2:0], 3'h3);
		wait_on(5, 3000);
		check(mach_out[2:0], 3'h6);
		check(seg_out, 7'h5B);
		wait_on(2, 3000);
		check(waited >= 240 * UNIT * TICK && waited < 240 * UNIT * TICK + 200, 1'b1);
		repeat (3) @(negedge sys_clk);
		check({mach_out, step_bcd, busy}, 16'h0);
		$display("run done");
	endtask : t_run
	task automatic t_jam();
		jam = 1'b1;
		ctl = 3'h7;
		wait_on(0, 200);
		ctl = 3'h0;
		wait_on(1, 1000);
		repeat (2) @(negedge sys_clk);
		check({mach_out, step_bcd, busy}, 16'h0);
		jam = 1'b0;
		repeat (40) @(negedge sys_clk);
		t_run();
		check(jam_flag, 1'b0);
		$display("jam done");
	endtask : t_jam
	////////////////////////////////////////
	initial begin
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk) rst = 1'b0;
		t_hold();
		t_partial();
		t_run();
		t_jam();
		stop_test();
	end
endmodule : machine_step_sequencer_test
